// >>> dv/spc_slave_model.sv
// spc_slave_model: behavioural slave on the far end of the serial link
// assumes sck idles low and busy_i marks an open frame
`timescale 1ns/10ps
`default_nettype none
module spc_slave_model #(
   parameter logic [7:0] REPLY = 8'h5a
) (
   // serial link
   input wire logic sck_i,
   input wire logic mosi_i,
   input wire logic busy_i,
   output logic miso_o,
   // last byte seen
   output logic [7:0] got_o
);
   logic [7:0] sh; // reply shifter
   int cnt; // falling edges in this byte
   initial begin
      sh = REPLY;
      got_o = 8'h00;
      cnt = 0;
   end
   // take data on rising sck, msb first
   always @(posedge sck_i) begin
      got_o <= {got_o[6:0], mosi_i};
   end
   // change data on falling sck, reload after a whole byte
   always @(negedge sck_i) begin
      if (cnt == 7) begin
         sh <= REPLY;
         cnt <= 0;
      end else begin
         sh <= {sh[6:0], 1'b0};
         cnt <= cnt + 1;
      end
   end
   // outside a frame show the inverse, never a stale level
   assign miso_o = busy_i ? sh[7] : ~sh[7];
endmodule
`default_nettype wire

// >>> dv/tb_top.sv
// tb_top: self-checking bench for spc_core
// assumes spc_core, spc_fifo and spc_slave_model compiled first
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   // ----------------------------------------
   // stimulus, wiring, counters
   // ----------------------------------------
   logic clock_i = 1'b0;
   logic rst_i = 1'b1;
   logic en = 1'b0, ie = 1'b1, stp = 1'b0, wt = 1'b0, msk = 1'b0;
   logic sr = 1'b0, da = 1'b0, cw = 1'b0, flt = 1'b0, tv = 1'b0;
   logic [2:0] rate = 3'h2;
   logic [7:0] td = 8'h00;
   logic [7:0] rx, got;
   logic rdy, done, fault, busy, irq, wake, sck, mosi, miso;
   int error_cnt = 0;
   int n_tests = 0;
   always #4 clock_i = ~clock_i;
   spc_core dut_u (.clock_i(clock_i), .rst_i(rst_i), .serial_enable_i(en),
      .irq_enable_i(ie), .rate_select_field_i(rate), .stop_mode_i(stp),
      .wait_mode_i(wt), .irq_mask_i(msk), .status_read_i(sr), .data_access_i(da),
      .control_write_i(cw), .fault_in_i(flt), .tx_valid_i(tv), .tx_ready_o(rdy),
      .tx_data_i(td), .rx_data_o(rx), .transfer_done_flag_o(done),
      .fault_flag_o(fault), .busy_o(busy), .irq_o(irq), .wake_o(wake),
      .sck_o(sck), .mosi_o(mosi), .miso_i(miso));
   spc_slave_model slv_u (.sck_i(sck), .mosi_i(mosi), .busy_i(busy), .miso_o(miso),
      .got_o(got));
   // ----------------------------------------
   // shared tasks
   // ----------------------------------------
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_tests++;
      if (seen !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic give_verdict();
      $display("tests %0d errors %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // push one byte, then wait bounded for the flag
   task automatic xfer(input logic [7:0] b);
      int k;
      @(posedge clock_i) begin tv <= 1'b1; td <= b; end
      @(posedge clock_i) tv <= 1'b0;
      for (k = 0; k < 5000 && done !== 1'b1; k++) @(posedge clock_i);
   endtask
   // two-step flag clear: status read, then data access
   task automatic clr();
      @(posedge clock_i) sr <= 1'b1;
      @(posedge clock_i) begin sr <= 1'b0; da <= 1'b1; end
      @(posedge clock_i) da <= 1'b0;
      @(posedge clock_i);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_disabled();
      int k;
      xfer(8'ha5); // core gated, byte waits in the fifo
      chk({busy, sck, done}, 16'h0);
      en <= 1'b1; // enable last, flags already clear
      xfer(8'h00);
      wt <= 1'b1;
      @(posedge clock_i);
      chk(done, 1'b1);
      chk(got, 8'ha5);
      chk(rx, 8'h5a);
      chk({irq, wake}, 2'h3);
      clr();
      chk({done, irq, wake}, 3'h0);
      wt <= 1'b0;
      // let the second byte finish so later scenarios start idle
      for (k = 0; k < 5000 && done !== 1'b1; k++) @(posedge clock_i);
      chk(done, 1'b1);
      chk(got, 8'h00);
      clr();
   endtask
   task automatic t_fault();
      @(posedge clock_i) flt <= 1'b1;
      @(posedge clock_i) flt <= 1'b0;
      @(posedge clock_i) msk <= 1'b1;
      chk({fault, irq}, 2'h3);
      @(posedge clock_i) msk <= 1'b0;
      chk(irq, 1'b0);
      sr <= 1'b1;
      @(posedge clock_i) begin sr <= 1'b0; cw <= 1'b1; end
      @(posedge clock_i) cw <= 1'b0;
      @(posedge clock_i);
      chk({fault, irq}, 2'h0);
   endtask
   // high phase of sck is one half of the selected divisor
   task automatic t_rate();
      int r, c, w;
      // code 7 is the slowest rate, as slow setups use
      for (r = 0; r < 8; r++) begin
         rate <= r[2:0];
         @(posedge clock_i) begin tv <= 1'b1; td <= 8'h3c; end
         @(posedge clock_i) tv <= 1'b0;
         for (w = 0; w < 400 && sck !== 1'b1; w++) @(posedge clock_i);
         for (c = 0; c < 400 && sck === 1'b1; c++) @(posedge clock_i);
         chk(c[15:0], 16'h1 << r);
         for (w = 0; w < 5000 && done !== 1'b1; w++) @(posedge clock_i);
         chk(done, 1'b1);
         clr();
      end
      rate <= 3'h2;
   endtask
   task automatic t_stop();
      logic s;
      @(posedge clock_i) begin tv <= 1'b1; td <= 8'h81; end
      @(posedge clock_i) tv <= 1'b0;
      repeat (20) @(posedge clock_i);
      stp <= 1'b1;
      @(posedge clock_i);
      @(posedge clock_i) s = sck;
      repeat (50) @(posedge clock_i);
      chk({busy, sck, done}, {1'b1, s, 1'b0});
      stp <= 1'b0;
      xfer(8'h00);
      chk(done, 1'b1);
      clr();
      @(posedge clock_i) begin tv <= 1'b1; td <= 8'h18; end
      @(posedge clock_i) tv <= 1'b0;
      repeat (20) @(posedge clock_i);
      stp <= 1'b1;
      repeat (5) @(posedge clock_i);
      rst_i <= 1'b1;
      @(posedge clock_i) begin rst_i <= 1'b0; stp <= 1'b0; end
      @(posedge clock_i);
      chk({done, fault, busy, sck, irq, rdy}, 6'h01);
   endtask
   // ----------------------------------------
   // main sequence and watchdog
   // ----------------------------------------
   initial begin
      repeat (4) @(posedge clock_i);
      rst_i <= 1'b0;
      @(posedge clock_i);
      // select (busy) idles low-inactive before any setup
      chk({done, fault, busy, sck, irq, rdy}, 6'h01);
      t_disabled();
      t_fault();
      t_rate();
      t_stop();
      give_verdict();
   end
   // whole run should need well under 30000 cycles
   initial begin
      repeat (60000) @(posedge clock_i);
      error_cnt++;
      give_verdict();
   end
endmodule
`default_nettype wire

// >>> hdl/spc_core.sv
// spc_core.sv: serial master core with power modes and shared interrupt
// assumes miso_i is asynchronous; control ports come from same-clock logic
// What this block does
// - enable clear stops core, controls stay writable
// - runs in wait; enabled irq gives wake
// - stop halts serial, registers kept, resume
// - reset out of stop aborts transfer
// - data shifted across stop is invalid
// - done and fault share one irq
// - done cleared by status read, data access
// - rate field divides by 2 to 256
// - done set after eighth clock, irq if enabled
`timescale 1ns/10ps
`default_nettype none
`include "spc_defines.svh"
module spc_core #(
   parameter int FIFO_DEPTH = `SPC_FIFO_DEPTH
) (
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // configuration
   input wire logic serial_enable_i,
   input wire logic irq_enable_i,
   input wire logic [2:0] rate_select_field_i,
   input wire logic stop_mode_i,
   input wire logic wait_mode_i,
   input wire logic irq_mask_i,
   // status access strobes
   input wire logic status_read_i,
   input wire logic data_access_i,
   input wire logic control_write_i,
   input wire logic fault_in_i,
   // transmit stream
   input wire logic tx_valid_i,
   output logic tx_ready_o,
   input wire logic [7:0] tx_data_i,
   // received data and status
   output logic [7:0] rx_data_o,
   output logic transfer_done_flag_o,
   output logic fault_flag_o,
   output logic busy_o,
   output logic irq_o,
   output logic wake_o,
   // serial pins
   output logic sck_o,
   output logic mosi_o,
   input wire logic miso_i
);
   initial begin
      if (FIFO_DEPTH < 2) $error("fifo too shallow");
   end
   // ----------------------------------------
   // input sync and fifo
   // ----------------------------------------
   logic miso_s1, miso_s2;   // first stage read only by second
   logic q_valid, q_ready;
   logic [7:0] q_data;
   always_ff @(posedge clock_i) begin
      miso_s1 <= miso_i;
      miso_s2 <= miso_s1;
   end
   spc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .in_valid_i(tx_valid_i),
      .in_ready_o(tx_ready_o),
      .in_data_i(tx_data_i),
      .out_valid_o(q_valid),
      .out_ready_i(q_ready),
      .out_data_o(q_data)
   );
   // ----------------------------------------
   // transfer engine
   // ----------------------------------------
   spc_pkg::spc_state_t state, next_state;
   logic [7:0] div_cnt, next_div_cnt, shift, next_shift, rx, next_rx;
   logic [3:0] bit_cnt, next_bit_cnt;
   logic done, next_done, fault, next_fault, armed, next_armed;
   logic fault_armed, next_fault_armed;   // separate arm so a fault clear leaves done alone
   logic run, tick;
   logic [7:0] half;
   // core runs only when enabled and not stopped; wait keeps it going
   assign run = serial_enable_i && !stop_mode_i;
   // half period = divisor/2 = 1 << code
   assign half = 8'h1 << rate_select_field_i;
   assign tick = (div_cnt == half - 8'h1);
   assign q_ready = run && state == spc_pkg::SPC_IDLE;
   always_comb begin
      next_state = state;
      next_div_cnt = div_cnt;
      next_shift = shift;
      next_bit_cnt = bit_cnt;
      next_rx = rx;
      next_done = done;
      next_fault = fault;
      next_armed = armed;
      next_fault_armed = fault_armed;
      // status read with flag set arms the matching clear
      if (status_read_i && done) next_armed = 1'b1;
      if (status_read_i && fault) next_fault_armed = 1'b1;
      if (data_access_i && armed) begin
         next_done = 1'b0;
         next_armed = 1'b0;
      end
      if (control_write_i && fault_armed) begin
         next_fault = 1'b0;
         next_fault_armed = 1'b0;
      end
      if (fault_in_i) next_fault = 1'b1;   // set wins over clear
      if (run) begin
         case (state)
            spc_pkg::SPC_IDLE: begin
               next_div_cnt = 8'h0;
               if (q_valid) begin
                  next_shift = q_data;
                  next_bit_cnt = 4'h0;
                  next_state = spc_pkg::SPC_LOW;
               end
            end
            spc_pkg::SPC_LOW: begin   // clock low half, data set up
               next_div_cnt = tick ? 8'h0 : div_cnt + 8'h1;
               if (tick) begin
                  next_rx = {rx[6:0], miso_s2};   // sample on rising edge
                  next_state = spc_pkg::SPC_HIGH;
               end
            end
            spc_pkg::SPC_HIGH: begin
               next_div_cnt = tick ? 8'h0 : div_cnt + 8'h1;
               if (tick) begin
                  next_shift = {shift[6:0], 1'b0};
                  next_bit_cnt = bit_cnt + 4'h1;
                  next_state = (bit_cnt == `SPC_BITS_PER_XFER - 4'h1) ?
                     spc_pkg::SPC_DONE : spc_pkg::SPC_LOW;
               end
            end
            spc_pkg::SPC_DONE: begin   // after eighth clock
               next_done = 1'b1;
               next_state = spc_pkg::SPC_IDLE;
            end
            default: next_state = spc_pkg::SPC_IDLE;
         endcase
      end
      // stop freezes engine in place; shifted data then untrusted
   end
   always_ff @(posedge clock_i) begin
      if (rst_i) begin   // synchronous reset, also when applied during stop; leaving stop alone resets nothing
         state <= spc_pkg::SPC_IDLE;
         div_cnt <= 8'h0;
         shift <= 8'h0;
         rx <= 8'h0;
         bit_cnt <= 4'h0;
         done <= 1'b0;
         fault <= 1'b0;
         armed <= 1'b0;
         fault_armed <= 1'b0;
      end else begin
         state <= next_state;
         div_cnt <= next_div_cnt;
         shift <= next_shift;
         rx <= next_rx;
         bit_cnt <= next_bit_cnt;
         done <= next_done;
         fault <= next_fault;
         armed <= next_armed;
         fault_armed <= next_fault_armed;
      end
   end
   // ----------------------------------------
   // outputs and shared interrupt
   // ----------------------------------------
   logic irq_req;
   assign irq_req = irq_enable_i && (done || fault);
   assign irq_o = irq_req && !irq_mask_i;
   assign wake_o = irq_o && wait_mode_i;
   assign sck_o = state == spc_pkg::SPC_HIGH;   // idles low
   assign mosi_o = shift[7];
   assign rx_data_o = rx;
   assign transfer_done_flag_o = done;
   assign fault_flag_o = fault;
   assign busy_o = state != spc_pkg::SPC_IDLE;
   // ----------------------------------------
   // checks
   // ----------------------------------------
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);
   halt_core_a: assert property (!run |=> $stable(state)) else $error("core moved");
   irq_tie_a: assert property (irq_o == (irq_enable_i && !irq_mask_i && (done||fault)))
      else $error("irq mismatch");
   done_set_a: assert property (state == spc_pkg::SPC_DONE && run |=> done)
      else $error("done not set");
   clear_two_a: assert property (data_access_i && !armed && !status_read_i |=>
      done || !$past(done)) else $error("clear without read");
   wake_ok_a: assert property (wait_mode_i && irq_o |-> wake_o) else $error("no wake");
   sck_idle_a: assert property (state == spc_pkg::SPC_IDLE |-> !sck_o) else $error("sck");
   stop_keep_a: assert property (stop_mode_i && !status_read_i && !data_access_i &&
      !fault_in_i |=> $stable(done)) else $error("stop changed flag");
   eight_a: assert property (state == spc_pkg::SPC_DONE |-> bit_cnt == 4'h8)
      else $error("bit count");
   xfer_c: cover property (state == spc_pkg::SPC_DONE);
   fault_c: cover property (fault && irq_o);
   stop_c: cover property (stop_mode_i && busy_o);
endmodule
`default_nettype wire

// >>> hdl/spc_defines.svh
// spc_defines.svh: offsets-free constants for the serial power/irq block
// assumes inclusion by bare name from hdl/ sources
`ifndef SPC_DEFINES_SVH
`define SPC_DEFINES_SVH
// ----------------------------------------
// rate, framing, vector and fifo constants
// ----------------------------------------
`define SPC_RATE_RESET 3'h0
`define SPC_BITS_PER_XFER 4'h8
`define SPC_VECTOR_HI 16'hffd8
`define SPC_VECTOR_LO 16'hffd9
`define SPC_FIFO_DEPTH 32
`endif

// >>> hdl/spc_fifo.sv
// spc_fifo.sv: flip-flop fifo with valid/ready on both sides
// assumes one clock and synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none
module spc_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_i,
   // fill side
   input wire logic in_valid_i,
   output logic in_ready_o,
   input wire logic [WIDTH-1:0] in_data_i,
   // drain side
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [WIDTH-1:0] out_data_o
);
   localparam int AW = $clog2(DEPTH);
   initial begin
      if (DEPTH < 2 || (1 << AW) != DEPTH) $error("depth must be power of two");
   end
   logic [WIDTH-1:0] mem [DEPTH];   // storage
   logic [AW:0] wr_ptr, rd_ptr, next_wr_ptr, next_rd_ptr;
   logic push, pop;
   assign in_ready_o = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
   assign out_valid_o = wr_ptr != rd_ptr;
   assign out_data_o = mem[rd_ptr[AW-1:0]];
   // ----------------------------------------
   // pointer update
   // ----------------------------------------
   always_comb begin
      push = in_valid_i && in_ready_o;
      pop = out_valid_o && out_ready_i;
      next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
      next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
   end
   always_ff @(posedge clock_i) begin
      if (rst_i) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         wr_ptr <= next_wr_ptr;
         rd_ptr <= next_rd_ptr;
      end
      if (push) mem[wr_ptr[AW-1:0]] <= in_data_i;
   end
endmodule
`default_nettype wire

// >>> hdl/spc_pkg.sv
// spc_pkg.sv: types shared by the serial power/irq block
// assumes nothing beyond a SystemVerilog compiler
package spc_pkg;
   // transfer engine states, one-hot
   typedef enum logic [3:0] {
      SPC_IDLE = 4'h1,
      SPC_LOW = 4'h2,
      SPC_HIGH = 4'h4,
      SPC_DONE = 4'h8
   } spc_state_t;
endpackage
